// >>> design/interrupt_source_logic.sv
// What this block does
// - Pin polarity bit picks rising or falling edge.
// - Selected edge sets that pin's flag.
// - Pin request only while its enable set.
// - Enabled pin interrupt wakes core from sleep.
// - After wake, vector only if global enable.
// - Pin one/two priority from bits 6, 7.
// - Pin zero always high priority.
// - Eight-bit timer wrap FFh to 00h sets flag.
// - Sixteen-bit timer wrap FFFFh to 0000h sets flag.
// - Timer request gated by enable; own priority bit.
// - Port B 7:4 level change sets flag.
// - Port change gated by enable; own priority bit.
// - Accept pushes return address onto call stack.
// - Accept shadows working, status, bank registers.
// - Priority enable picks two-level or single-level.
`timescale 1ns/1ps
module interrupt_source_logic #(
	parameter int PC_W = irq_src_pkg::PC_WIDTH
) (
	input  wire logic                                i_clk,
	input  wire logic                                i_rst_b,
	input  wire logic [irq_src_pkg::NUM_EXT_PINS-1:0] i_ext_pin,
	input  wire logic [irq_src_pkg::NUM_EXT_PINS-1:0] i_ext_edge_polarity_sel,
	input  wire logic [irq_src_pkg::NUM_EXT_PINS-1:0] i_ext_flag_clr,
	input  wire irq_src_pkg::irq_enable_s             i_enable,
	input  wire logic [7:0]                          i_irq_control_third,
	input  wire logic                                i_timer_overflow_priority,
	input  wire logic                                i_port_change_priority,
	input  wire logic                                i_timer_mode_8bit,
	input  wire logic [15:0]                         i_timer_count,
	input  wire logic                                i_timer_flag_clr,
	input  wire logic [irq_src_pkg::PORT_CHG_WIDTH-1:0] i_port_b_high,
	input  wire logic                                i_port_change_flag_clr,
	input  wire logic                                i_sleep,
	input  wire logic                                i_irq_ack,
	input  wire logic [PC_W-1:0]                     i_return_pc,
	input  wire irq_src_pkg::context_s                i_context,
	output logic [irq_src_pkg::NUM_EXT_PINS-1:0]      o_ext_pin_irq_flag,
	output logic                                     o_timer_overflow_flag,
	output logic                                     o_port_change_flag,
	output logic                                     o_irq_high,
	output logic                                     o_irq_low,
	output logic                                     o_wake,
	output logic                                     o_vector_after_wake,
	output logic                                     o_stack_push,
	output logic [PC_W-1:0]                          o_stack_push_pc,
	output irq_src_pkg::context_s                     o_fast_shadow
);
	import irq_src_pkg::*;

	logic [NUM_EXT_PINS-1:0]   pin_last_q, pin_last_d;
	logic [NUM_EXT_PINS-1:0]   ext_flag_q, ext_flag_d;
	logic [PORT_CHG_WIDTH-1:0] sync1_q, sync1_d;
	logic [PORT_CHG_WIDTH-1:0] sync2_q, sync2_d;
	logic [PORT_CHG_WIDTH-1:0] port_last_q, port_last_d;
	logic [2:0]                port_primed_q, port_primed_d;
	logic                      port_flag_q, port_flag_d;
	logic [15:0]               timer_last_q, timer_last_d;
	logic                      timer_primed_q, timer_primed_d;
	logic                      timer_flag_q, timer_flag_d;
	logic [NUM_EXT_PINS-1:0]   sleep_en_q, sleep_en_d;
	core_state_e               state_q, state_d;
	logic                      wake_q, wake_d;
	logic                      vec_q, vec_d;
	logic                      push_q, push_d;
	logic [PC_W-1:0]           push_pc_q, push_pc_d;
	context_s                  shadow_q, shadow_d;

	logic [NUM_EXT_PINS-1:0] edge_hit;
	logic                    timer_wrap;
	logic                    port_change;
	logic [NUM_EXT_PINS-1:0] pin_req;
	logic [NUM_EXT_PINS-1:0] pin_prio;
	logic                    timer_req;
	logic                    port_req;
	logic                    req_hi;
	logic                    req_lo;
	logic                    wake_event;

	// Sampled edge detector; the polarity bit chooses the direction.
	function automatic logic edge_seen(input logic prev, input logic now,
		input logic rising);
		edge_seen = rising ? (!prev && now) : (prev && !now);
	endfunction

	always_comb begin
		for (int i = 0; i < NUM_EXT_PINS; i++) begin
			edge_hit[i] = edge_seen(pin_last_q[i], i_ext_pin[i],
				i_ext_edge_polarity_sel[i]);
		end
		if (i_timer_mode_8bit) begin
			timer_wrap = timer_primed_q &&
				timer_last_q[7:0] == TIMER8_MAX &&
				i_timer_count[7:0] == TIMER8_MIN;
		end else begin
			timer_wrap = timer_primed_q && timer_last_q == TIMER16_MAX &&
				i_timer_count == TIMER16_MIN;
		end
		// Compares wait until both sync stages and the latch hold real
		// samples, so a port that powers up high raises no false change.
		port_change = port_primed_q[2] &&
			(sync2_q != port_last_q);
	end

	always_comb begin
		pin_last_d     = i_ext_pin;
		sync1_d        = i_port_b_high;
		sync2_d        = sync1_q;
		port_last_d    = sync2_q;
		port_primed_d  = {port_primed_q[1:0], 1'b1};
		timer_last_d   = i_timer_count;
		timer_primed_d = 1'b1;
		// A set in the same cycle as a clear wins, so no event is lost.
		// Flags ignore the enable bits.
		ext_flag_d   = (ext_flag_q & ~i_ext_flag_clr) | edge_hit;
		timer_flag_d = (timer_flag_q && !i_timer_flag_clr) || timer_wrap;
		port_flag_d  = (port_flag_q && !i_port_change_flag_clr) ||
			port_change;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pin_last_q     <= EXT_FLAG_RST;
			ext_flag_q     <= EXT_FLAG_RST;
			sync1_q        <= PORT_LAST_RST;
			sync2_q        <= PORT_LAST_RST;
			port_last_q    <= PORT_LAST_RST;
			port_primed_q  <= '0;
			port_flag_q    <= FLAG_RST;
			timer_last_q   <= TIMER16_MIN;
			timer_primed_q <= FLAG_RST;
			timer_flag_q   <= FLAG_RST;
		end else begin
			pin_last_q     <= pin_last_d;
			ext_flag_q     <= ext_flag_d;
			sync1_q        <= sync1_d;
			sync2_q        <= sync2_d;
			port_last_q    <= port_last_d;
			port_primed_q  <= port_primed_d;
			port_flag_q    <= port_flag_d;
			timer_last_q   <= timer_last_d;
			timer_primed_q <= timer_primed_d;
			timer_flag_q   <= timer_flag_d;
		end
	end

	always_comb begin
		pin_req   = ext_flag_q & i_enable.ext_pin_irq_en;
		timer_req = timer_flag_q && i_enable.timer_overflow_en;
		port_req  = port_flag_q && i_enable.port_change_en;
		pin_prio[0] = 1'b1;
		pin_prio[1] = i_irq_control_third[PRIO_PIN1_BIT];
		pin_prio[2] = i_irq_control_third[PRIO_PIN2_BIT];
		if (i_enable.priority_scheme_en) begin
			req_hi = |(pin_req & pin_prio) ||
				(timer_req && i_timer_overflow_priority) ||
				(port_req && i_port_change_priority);
			req_lo = |(pin_req & ~pin_prio) ||
				(timer_req && !i_timer_overflow_priority) ||
				(port_req && !i_port_change_priority);
		end else begin
			// Single-level scheme: every source shares the one vector.
			req_hi = |pin_req || timer_req || port_req;
			req_lo = 1'b0;
		end
	end

	assign o_irq_high = req_hi && i_enable.global_irq_en;
	assign o_irq_low  = req_lo && i_enable.global_irq_en;

	always_comb begin
		state_d    = state_q;
		sleep_en_d = sleep_en_q;
		wake_d     = 1'b0;
		vec_d      = vec_q;
		wake_event = |(ext_flag_q & sleep_en_q);
		case (state_q)
			CORE_RUN: begin
				vec_d = 1'b0;
				if (i_sleep) begin
					// Enables are frozen on entry; later changes do not
					// arm a wake source.
					sleep_en_d = i_enable.ext_pin_irq_en;
					state_d    = CORE_SLEEP;
				end
			end
			CORE_SLEEP: begin
				if (wake_event) begin
					wake_d  = 1'b1;
					vec_d   = i_enable.global_irq_en;
					state_d = CORE_WAKE;
				end else if (!i_sleep) begin
					// The core left sleep for another reason; do not
					// stay armed with stale enables.
					state_d = CORE_RUN;
				end
			end
			CORE_WAKE: begin
				if (!i_sleep) begin
					state_d = CORE_RUN;
				end
			end
			default: begin
				state_d = CORE_RUN;
			end
		endcase
	end

	always_comb begin
		push_d    = i_irq_ack;
		push_pc_d = i_irq_ack ? i_return_pc : push_pc_q;
		shadow_d  = i_irq_ack ? i_context : shadow_q;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q    <= CORE_RUN;
			sleep_en_q <= EXT_FLAG_RST;
			wake_q     <= FLAG_RST;
			vec_q      <= FLAG_RST;
			push_q     <= FLAG_RST;
			push_pc_q  <= '0;
			shadow_q   <= '0;
		end else begin
			state_q    <= state_d;
			sleep_en_q <= sleep_en_d;
			wake_q     <= wake_d;
			vec_q      <= vec_d;
			push_q     <= push_d;
			push_pc_q  <= push_pc_d;
			shadow_q   <= shadow_d;
		end
	end

	assign o_ext_pin_irq_flag    = ext_flag_q;
	assign o_timer_overflow_flag = timer_flag_q;
	assign o_port_change_flag    = port_flag_q;
	assign o_wake                = wake_q;
	assign o_vector_after_wake   = vec_q;
	assign o_stack_push          = push_q;
	assign o_stack_push_pc       = push_pc_q;
	assign o_fast_shadow         = shadow_q;

endmodule

// >>> design/irq_src_pkg.sv
package irq_src_pkg;

	localparam int NUM_EXT_PINS   = 3;
	localparam int PORT_CHG_WIDTH = 4;
	localparam int TIMER_WIDTH    = 16;
	localparam int DATA_WIDTH     = 8;
	localparam int PC_WIDTH       = 21;

	// Reset values of the flags and the latched port levels.
	localparam logic [2:0] EXT_FLAG_RST  = 3'h0;
	localparam logic [3:0] PORT_LAST_RST = 4'h0;
	localparam logic       FLAG_RST      = 1'b0;

	// Timer wrap points for the two counting modes.
	localparam logic [7:0]  TIMER8_MAX  = 8'hff;
	localparam logic [7:0]  TIMER8_MIN  = 8'h00;
	localparam logic [15:0] TIMER16_MAX = 16'hffff;
	localparam logic [15:0] TIMER16_MIN = 16'h0000;

	// Priority bit positions inside the third control register.
	localparam int PRIO_PIN1_BIT = 6;
	localparam int PRIO_PIN2_BIT = 7;

	typedef struct packed {
		logic [DATA_WIDTH-1:0] working_register;
		logic [DATA_WIDTH-1:0] status_register;
		logic [DATA_WIDTH-1:0] bank_select_register;
	} context_s;

	typedef struct packed {
		logic [NUM_EXT_PINS-1:0] ext_pin_irq_en;
		logic                    timer_overflow_en;
		logic                    port_change_en;
		logic                    global_irq_en;
		logic                    priority_scheme_en;
	} irq_enable_s;

	typedef enum logic [1:0] {
		CORE_RUN   = 2'b00,
		CORE_SLEEP = 2'b01,
		CORE_WAKE  = 2'b11
	} core_state_e;

endpackage

// >>> dv/irq_src_checker.sv
`timescale 1ns/1ps
module irq_src_checker #(
	parameter int PC_W = 21
) (
	input wire logic                    i_clk,
	input wire logic                    i_rst_b,
	input wire logic [2:0]              i_ext_pin,
	input wire logic [2:0]              i_ext_edge_polarity_sel,
	input wire irq_src_pkg::irq_enable_s i_enable,
	input wire logic                    i_timer_mode_8bit,
	input wire logic [15:0]             i_timer_count,
	input wire logic                    i_irq_ack,
	input wire logic [PC_W-1:0]         i_return_pc,
	input wire irq_src_pkg::context_s   i_context,
	input wire logic [2:0]              o_ext_pin_irq_flag,
	input wire logic                    o_timer_overflow_flag,
	input wire logic                    o_port_change_flag,
	input wire logic                    o_irq_high,
	input wire logic                    o_irq_low,
	input wire logic                    o_stack_push,
	input wire logic [PC_W-1:0]         o_stack_push_pc,
	input wire irq_src_pkg::context_s   o_fast_shadow
);
	import irq_src_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	AST_EDGE_SEL: assert property ((i_ext_edge_polarity_sel[0] ?
		$rose(i_ext_pin[0]) : $fell(i_ext_pin[0])) |=> o_ext_pin_irq_flag[0])
		else $error("pin flag missed");
	AST_T8: assert property (i_timer_mode_8bit &&
		$past(i_timer_count[7:0]) == 8'hff && i_timer_count[7:0] == 8'h00
		|=> o_timer_overflow_flag) else $error("8-bit wrap missed");
	AST_T16: assert property (!i_timer_mode_8bit &&
		$past(i_timer_count) == 16'hffff && i_timer_count == 16'h0000
		|=> o_timer_overflow_flag) else $error("16-bit wrap missed");
	AST_PUSH: assert property (i_irq_ack |=> o_stack_push &&
		o_stack_push_pc == $past(i_return_pc) &&
		o_fast_shadow == $past(i_context)) else $error("bad push");
	AST_PUSH_ONLY: assert property (!i_irq_ack |=> !o_stack_push)
		else $error("push without accept");
	AST_SINGLE: assert property (!i_enable.priority_scheme_en |-> !o_irq_low)
		else $error("low request in single level");
	AST_GATE: assert property (!i_enable.global_irq_en |->
		!(o_irq_high || o_irq_low)) else $error("request while disabled");
	AST_PIN0: assert property (o_ext_pin_irq_flag[0] &&
		i_enable.ext_pin_irq_en[0] && i_enable.global_irq_en |-> o_irq_high)
		else $error("pin zero not high");
	AST_PIN_GATE: assert property (!(|(o_ext_pin_irq_flag &
		i_enable.ext_pin_irq_en)) &&
		!(o_timer_overflow_flag && i_enable.timer_overflow_en) &&
		!(o_port_change_flag && i_enable.port_change_en)
		|-> !(o_irq_high || o_irq_low)) else $error("request without enable");
	cover property (o_stack_push);
	cover property (o_irq_low);
	cover property (o_timer_overflow_flag);
endmodule

bind interrupt_source_logic irq_src_checker #(.PC_W(PC_W)) i_chk (.*);

// >>> dv/core_side_model.sv
`timescale 1ns/1ps
module core_side_model (
	input  wire logic                        i_clk,
	input  wire logic                        i_rst_b,
	input  wire logic                        i_irq,
	input  wire logic [3:0]                  i_delay,
	output logic                             o_ack,
	output logic [irq_src_pkg::PC_WIDTH-1:0] o_pc,
	output irq_src_pkg::context_s            o_ctx
);
	import irq_src_pkg::*;
	logic [3:0] wait_q;
	// Pc and context move every cycle, so a late sample is caught.
	assign o_ctx = {o_pc[7:0], ~o_pc[7:0], 8'h5a};
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pc <= '0;
			wait_q <= '0;
			o_ack <= 1'b0;
		end else begin
			o_pc <= o_pc + 1'b1;
			o_ack <= i_irq && wait_q == i_delay;
			wait_q <= (i_irq && wait_q <= i_delay) ? wait_q + 4'h1 : 4'h0;
		end
	end
endmodule

// >>> dv/interrupt_source_logic_tb.sv
`timescale 1ns/1ps
module interrupt_source_logic_tb;
	import irq_src_pkg::*;
	logic        i_clk, i_rst_b, mode8, tclr, pclr, slp, tpr, ppr, ack;
	logic        tf, pf, hi, lo, wake, vec, push;
	logic [2:0]  pin, pol, eclr, flag;
	logic [3:0]  portb, dly;
	logic [7:0]  third;
	logic [15:0] cnt;
	logic [20:0] rpc, spc;
	irq_enable_s en;
	context_s    ctx, shd;
	int          errors, n_compared;
	interrupt_source_logic i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_ext_pin(pin), .i_ext_edge_polarity_sel(pol), .i_ext_flag_clr(eclr),
		.i_enable(en), .i_irq_control_third(third),
		.i_timer_overflow_priority(tpr), .i_port_change_priority(ppr),
		.i_timer_mode_8bit(mode8), .i_timer_count(cnt), .i_timer_flag_clr(tclr),
		.i_port_b_high(portb), .i_port_change_flag_clr(pclr), .i_sleep(slp),
		.i_irq_ack(ack), .i_return_pc(rpc), .i_context(ctx),
		.o_ext_pin_irq_flag(flag), .o_timer_overflow_flag(tf),
		.o_port_change_flag(pf), .o_irq_high(hi), .o_irq_low(lo), .o_wake(wake),
		.o_vector_after_wake(vec), .o_stack_push(push), .o_stack_push_pc(spc),
		.o_fast_shadow(shd));
	core_side_model i_core (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_irq(hi | lo),
		.i_delay(dly), .o_ack(ack), .o_pc(rpc), .o_ctx(ctx));
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	task cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task chk(input string nm, input logic [23:0] got,
		input logic [23:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task conclude;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Software clears flags; the design never does it by itself.
	task clr_all;
		{eclr, tclr, pclr} = 5'h1f;
		cyc(1);
		{eclr, tclr, pclr} = 5'h00;
		cyc(1);
	endtask
	task t_pins;
		// Global enable on, pin enables off, so only the pin gate blocks.
		en = 7'h02;
		for (int p = 0; p < 3; p++) begin
			for (int v = 0; v < 2; v++) begin
				pol[p] = v[0];
				pin[p] = v[0];
				cyc(3);
				clr_all();
				pin[p] = !v[0];
				cyc(3);
				chk("wrong edge", flag[p], 1'b0);
				pin[p] = v[0];
				cyc(3);
				chk("pin flag", flag[p], 1'b1);
				chk("disabled", {hi, lo}, 2'b00);
			end
		end
	endtask
	task t_prio;
		logic [7:0] pcl;
		clr_all();
		dly = 4'h3;
		en = 7'h7f;
		pol[1] = 1'b0;
		pin[1] = 1'b0;
		cyc(3);
		chk("pin1 low", {hi, lo}, 2'b01);
		third = 8'h40;
		cyc(1);
		chk("pin1 high", {hi, lo}, 2'b10);
		for (int i = 0; i < 20 && push !== 1'b1; i++) cyc(1);
		chk("push", push, 1'b1);
		// The model's pc has moved on by one since the accepting edge.
		pcl = rpc[7:0] - 8'h1;
		chk("push pc", spc, rpc - 21'h1);
		chk("shadow", shd, {pcl, ~pcl, 8'h5a});
		cyc(1);
		chk("push pulse", push, 1'b0);
		en.priority_scheme_en = 1'b0;
		third = 8'h00;
		cyc(1);
		chk("single", {hi, lo}, 2'b10);
		en.ext_pin_irq_en[1] = 1'b0;
		cyc(1);
		chk("pin1 off", {hi, lo}, 2'b00);
		clr_all();
		en = 7'h7f;
		third = 8'h80;
		pol[2] = 1'b0;
		pin[2] = 1'b0;
		cyc(2);
		chk("pin2 high", {hi, lo}, 2'b10);
		third = 8'h40;
		cyc(1);
		chk("pin2 low", {hi, lo}, 2'b01);
	endtask
	task t_timer;
		clr_all();
		dly = 4'h0;
		en = 7'h0b;
		cnt = 16'h12ff;
		cyc(2);
		cnt = 16'h1300;
		cyc(3);
		chk("t8", {tf, hi, lo}, 3'h5);
		tpr = 1'b1;
		cyc(1);
		chk("t8 high", {tf, hi, lo}, 3'h6);
		tpr = 1'b0;
		clr_all();
		mode8 = 1'b0;
		cnt = 16'h00ff;
		cyc(2);
		cnt = 16'h0100;
		cyc(3);
		chk("low wrap", tf, 1'b0);
		cnt = 16'hffff;
		cyc(2);
		cnt = 16'h0000;
		cyc(3);
		en.timer_overflow_en = 1'b0;
		cyc(1);
		chk("t16", {tf, hi, lo}, 3'h4);
	endtask
	task t_port;
		clr_all();
		en = 7'h07;
		ppr = 1'b1;
		portb = 4'h8;
		cyc(4);
		chk("port", {pf, hi, lo}, 3'h6);
		clr_all();
		cyc(3);
		chk("steady", pf, 1'b0);
		en.port_change_en = 1'b0;
		portb = 4'h1;
		cyc(4);
		chk("port off", {pf, hi, lo}, 3'h4);
	endtask
	task t_sleep(input logic g);
		logic seen;
		logic v;
		seen = 1'b0;
		v = 1'b0;
		clr_all();
		en = {5'h04, g, 1'b1};
		slp = 1'b1;
		pol[0] = 1'b1;
		pin[0] = 1'b0;
		cyc(3);
		pin[0] = 1'b1;
		for (int i = 0; i < 8; i++) begin
			cyc(1);
			if (wake === 1'b1) begin
				seen = 1'b1;
				v = vec;
			end
		end
		chk("wake", seen, 1'b1);
		chk("vector", v, g);
		chk("pin0 high", hi, g);
		slp = 1'b0;
	endtask
	initial begin
		{i_rst_b, pin, pol, eclr, en, third, tpr, ppr, cnt} = '0;
		{tclr, portb, pclr, slp, dly, errors, n_compared} = '0;
		mode8 = 1'b1;
		repeat (3) @(posedge i_clk);
		#1 i_rst_b = 1'b1;
		cyc(2);
		chk("reset out", {flag, tf, pf, hi, lo, wake, vec, push}, 24'h0);
		t_pins();
		t_prio();
		t_timer();
		t_port();
		t_sleep(1'b0);
		t_sleep(1'b1);
		conclude();
	end
	initial begin
		#100000;
		errors++;
		conclude();
	end
endmodule
